// ---- dlc_conv_model.sv ----
// dlc_conv_model.sv: behavioural converter with two level latches
// assumes its pins are driven straight by the write controller
`timescale 1ns/10ps
module dlc_conv_model (
    // converter pins
    input  wire [7:0] data_i,
    input  wire       chip_select_n_i,
    input  wire       input_write_strobe_n_i,
    input  wire       transfer_write_strobe_n_i,
    input  wire       transfer_select_n_i,
    input  wire       input_latch_enable_i,
    // analog side, units of reference over 256
    output reg  [7:0] code_o,
    output wire [7:0] true_current_out_o,
    output wire [7:0] complement_current_out_o
);
reg  [7:0] in_reg;
// a floating or unknown pin reads as one
function automatic [7:0] lv8(input [7:0] v);
    for (int b = 0; b < 8; b++) lv8[b] = (v[b] !== 1'b0);
endfunction
wire [7:0] d_lv     = lv8(data_i);
wire       cs_lv_n  = (chip_select_n_i !== 1'b0);
wire       in_stb_n = (input_write_strobe_n_i !== 1'b0);
wire       tr_stb_n = (transfer_write_strobe_n_i !== 1'b0);
wire       tr_sel_n = (transfer_select_n_i !== 1'b0);
wire       latch_en = (input_latch_enable_i !== 1'b0);
always @* if (latch_en && !cs_lv_n && !in_stb_n) in_reg = d_lv;
always @* if (!tr_sel_n && !tr_stb_n) code_o = in_reg;
// bits steer to true or complement
assign true_current_out_o = code_o;
assign complement_current_out_o = 8'hFF - code_o;
endmodule // dlc_conv_model

// ---- dlc_host.v ----
// dlc_host.v: controller driving the pins of a dual-latch converter
// assumes the converter pins are wired straight to the outputs here
`timescale 1ns/10ps
`include "dlc_map.vh"

module dlc_host #(
    parameter STROBE_CYC = `DLC_STROBE_CYC,
    parameter HOLD_CYC   = `DLC_HOLD_CYC,
    parameter SETUP_CYC  = `DLC_SETUP_CYC
) (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_b_i,
    // user side
    input  wire [1:0] mode_i,
    input  wire       write_req_i,
    input  wire [7:0] write_data_i,
    input  wire       load_input_i,
    input  wire       load_transfer_i,
    input  wire       freeze_i,
    input  wire [7:0] flow_data_i,
    output wire       ready_o,
    output reg        done_o,
    // converter pins
    output reg  [7:0] data_o,
    output reg        chip_select_n_o,
    output reg        input_write_strobe_n_o,
    output reg        transfer_write_strobe_n_o,
    output reg        transfer_select_n_o,
    output reg        input_latch_enable_o
);

    ////////////////////////////////////////////////////////////////
    // sequencer states
    localparam ST_IDLE  = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_LOW   = 3'h2;
    localparam ST_HOLD  = 3'h3;
    localparam ST_FLOW  = 3'h4;

    // sequencer state, phase counter and latched request
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [15:0] count;
    reg  [15:0] next_count;
    reg         do_input;
    reg         do_transfer;
    reg  [1:0]  cur_mode;

    // zero-based last count for a phase
    // a count below one still gives a one-cycle phase
    function [15:0] dlc_last;
        input integer cyc;
        begin
            dlc_last = (cyc < 1) ? 16'h0000 : cyc[15:0] - 16'h0001;
        end
    endfunction

    // ready while idle or in flow mode; write requests are only taken while idle
    assign ready_o = (state == ST_IDLE) || (state == ST_FLOW);

    ////////////////////////////////////////////////////////////////
    // next state of the write sequencer
    always @* begin
        next_state = state;
        next_count = count + 16'h0001;
        case (state)
            ST_IDLE: begin
                next_count = 16'h0000;
                // flow mode wins over a pending write
                if (mode_i == `DLC_MODE_FLOW)
                    next_state = ST_FLOW;
                else if (write_req_i)
                    next_state = ST_SETUP;
            end
            ST_SETUP: begin
                if (count >= dlc_last(SETUP_CYC)) begin
                    next_state = ST_LOW;
                    next_count = 16'h0000;
                end
            end
            ST_LOW: begin
                if (count >= dlc_last(STROBE_CYC)) begin
                    next_state = ST_HOLD;
                    next_count = 16'h0000;
                end
            end
            ST_HOLD: begin
                if (count >= dlc_last(HOLD_CYC)) begin
                    next_state = ST_IDLE;
                    next_count = 16'h0000;
                end
            end
            ST_FLOW: begin
                next_count = 16'h0000;
                if (mode_i != `DLC_MODE_FLOW)
                    next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
                next_count = 16'h0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // sequencer registers and captured request
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state       <= ST_IDLE;
            count       <= 16'h0000;
            do_input    <= 1'b0;
            do_transfer <= 1'b0;
            cur_mode    <= `DLC_MODE_DOUBLE;
            done_o      <= 1'b0;
        end else begin
            state  <= next_state;
            count  <= next_count;
            // one-cycle pulse as the hold phase ends
            done_o <= (state == ST_HOLD) && (next_state == ST_IDLE);
            if (state == ST_IDLE && next_state == ST_SETUP) begin
                // mode kept so a change mid-write is ignored
                cur_mode <= mode_i;
                // single mode latches in input stage
                if (mode_i == `DLC_MODE_SINGLE) begin
                    do_input    <= 1'b1;
                    do_transfer <= 1'b0;
                end else begin
                    do_input    <= load_input_i;
                    do_transfer <= load_transfer_i;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // pin drive, all from flip-flops
    // registered pins keep the strobes free of glitches
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_o                    <= 8'h00;
            chip_select_n_o           <= 1'b1;
            input_write_strobe_n_o    <= 1'b1;
            transfer_write_strobe_n_o <= 1'b1;
            transfer_select_n_o       <= 1'b1;
            input_latch_enable_o      <= 1'b0;
        end else begin
            input_latch_enable_o <= ~freeze_i;
            case (next_state)
                ST_FLOW: begin
                    data_o                    <= flow_data_i;
                    chip_select_n_o           <= 1'b0;
                    input_write_strobe_n_o    <= 1'b0;
                    transfer_write_strobe_n_o <= 1'b0;
                    transfer_select_n_o       <= 1'b0;
                end
                ST_SETUP: begin
                    if (state == ST_IDLE)
                        data_o <= write_data_i;
                    input_write_strobe_n_o <= 1'b1;
                    if (mode_i == `DLC_MODE_SINGLE || cur_mode ==
                        `DLC_MODE_SINGLE && state != ST_IDLE) begin
                        chip_select_n_o           <= 1'b0;
                        transfer_write_strobe_n_o <= 1'b0;
                        transfer_select_n_o       <= 1'b0;
                    end else begin
                        chip_select_n_o           <= 1'b1;
                        transfer_write_strobe_n_o <= 1'b1;
                        transfer_select_n_o       <= 1'b1;
                    end
                end
                // strobes rise after the low phase
                ST_LOW: begin
                    chip_select_n_o        <= ~do_input;
                    input_write_strobe_n_o <= ~do_input;
                    if (cur_mode != `DLC_MODE_SINGLE) begin
                        transfer_write_strobe_n_o <= ~do_transfer;
                        transfer_select_n_o       <= ~do_transfer;
                    end
                end
                default: begin
                    input_write_strobe_n_o <= 1'b1;
                    // single mode leaves select and transfer pair low
                    if (cur_mode != `DLC_MODE_SINGLE) begin
                        chip_select_n_o           <= 1'b1;
                        transfer_write_strobe_n_o <= 1'b1;
                        transfer_select_n_o       <= 1'b1;
                    end
                end
            endcase
        end
    end

endmodule // dlc_host

// ---- dlc_host_checker.sv ----
// dlc_host_checker.sv: pin timing checks for the write controller
// assumes it is bound into dlc_host
`timescale 1ns/10ps
`include "dlc_map.vh"
module dlc_host_checker #(parameter int STROBE_CYC = `DLC_STROBE_CYC) (
    input logic       clk_i,
    input logic       rst_b_i,
    input logic [1:0] mode_i,
    input logic       load_input_i,
    input logic       ready_o,
    input logic [7:0] data_o,
    input logic       chip_select_n_o,
    input logic       input_write_strobe_n_o,
    input logic       transfer_write_strobe_n_o,
    input logic       transfer_select_n_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (!rst_b_i);
int lo_cnt;
// length of the current input strobe low phase
always @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i) lo_cnt <= 0;
    else lo_cnt <= input_write_strobe_n_o ? 0 : lo_cnt + 1;
a_strobe_min_width: assert property (
    $rose(input_write_strobe_n_o) && !ready_o |-> lo_cnt >= STROBE_CYC)
    else $error("input strobe too short");
a_transfer_stretched: assert property (
    $fell(transfer_write_strobe_n_o) && !ready_o
    |-> (!transfer_write_strobe_n_o)[*8]) else $error("short transfer");
a_data_during_strobe: assert property (
    !ready_o && !input_write_strobe_n_o |-> $stable(data_o))
    else $error("data moved under strobe");
a_data_hold: assert property (
    $rose(input_write_strobe_n_o) && !ready_o |-> $stable(data_o)[*3])
    else $error("data hold too short");
a_single_transparent: assert property (
    $fell(ready_o) && mode_i == 2'h1 |-> ##1 (!transfer_select_n_o)[*8])
    else $error("converter register not transparent");
a_single_input_latch: assert property (
    $rose(input_write_strobe_n_o) && mode_i == 2'h1
    |-> !transfer_write_strobe_n_o) else $error("wrong latching stage");
a_single_selects: assert property (
    !ready_o && mode_i == 2'h1
    |-> !chip_select_n_o) else $error("select high in single write");
a_select_decode: assert property (
    !ready_o && mode_i == 2'h0 && !load_input_i |-> chip_select_n_o)
    else $error("select low without input load");
endmodule // dlc_host_checker
bind dlc_host dlc_host_checker u_chk (.*);

// ---- dlc_host_tb_top.sv ----
// dlc_host_tb_top.sv: self-checking bench for the write controller
// assumes the converter model and checker are compiled alongside
`timescale 1ns/10ps
`include "dlc_map.vh"
module dlc_host_tb_top;
// falling edges waited from the taken request until done is seen
localparam int WR_CYC = `DLC_SETUP_CYC + `DLC_STROBE_CYC + `DLC_HOLD_CYC + 1;
reg        clk_i = 1'b0;
reg        rst_b_i = 1'b0;
reg  [1:0] mode_i = 2'h0;
reg        write_req_i = 1'b0;
reg        load_input_i = 1'b0;
reg        load_transfer_i = 1'b0;
reg        freeze_i = 1'b0;
reg  [7:0] write_data_i = 8'h00;
reg  [7:0] flow_data_i = 8'h00;
wire       ready_o, done_o, chip_select_n_o, input_write_strobe_n_o;
wire       transfer_write_strobe_n_o, transfer_select_n_o;
wire       input_latch_enable_o;
wire [7:0] data_o, code, i_true, i_comp;
int        num_errors = 0;
int        n_compared = 0;
always #10 clk_i = ~clk_i;
dlc_host DUT (.*);
dlc_conv_model u_conv (.data_i(data_o), .chip_select_n_i(chip_select_n_o),
    .input_write_strobe_n_i(input_write_strobe_n_o),
    .transfer_write_strobe_n_i(transfer_write_strobe_n_o),
    .transfer_select_n_i(transfer_select_n_o),
    .input_latch_enable_i(input_latch_enable_o), .code_o(code),
    .true_current_out_o(i_true), .complement_current_out_o(i_comp));
task automatic chk8(input [7:0] got, input [7:0] exp);
    n_compared++;
    if (got !== exp) begin
        num_errors++;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
endtask
// one write through the controller, then wait for done
task automatic wr(input [1:0] m, input [7:0] d, input li, input lt);
    int i;
    @(posedge clk_i);
    mode_i <= m;
    write_data_i <= d;
    load_input_i <= li;
    load_transfer_i <= lt;
    write_req_i <= 1'b1;
    @(posedge clk_i);
    write_req_i <= 1'b0;
    // look on the falling edge, clear of the launching edge
    for (i = 0; i < 99 && done_o !== 1'b1; i++) @(negedge clk_i);
    chk8(8'(i), 8'(WR_CYC));
    chk8({6'h00, ready_o, done_o}, 8'h03);
    @(posedge clk_i);
endtask
task automatic t_double;
    wr(2'h0, 8'h3C, 1'b1, 1'b1);
    chk8(i_true, 8'h3C);
    chk8(i_comp, 8'hC3);
    wr(2'h0, 8'h5A, 1'b1, 1'b0);
    chk8(code, 8'h3C);
    wr(2'h0, 8'h00, 1'b0, 1'b1);
    chk8(code, 8'h5A);
    $display("double buffered test done");
endtask
task automatic t_single;
    wr(2'h1, 8'h81, 1'b0, 1'b0);
    chk8(code, 8'h81);
    freeze_i <= 1'b1;
    wr(2'h1, 8'h11, 1'b0, 1'b0);
    chk8(code, 8'h81);
    freeze_i <= 1'b0;
    $display("single buffered test done");
endtask
task automatic t_flow;
    mode_i <= 2'h2;
    flow_data_i <= 8'h77;
    repeat (4) @(posedge clk_i);
    chk8(code, 8'h77);
    flow_data_i <= 8'hE8;
    repeat (3) @(posedge clk_i);
    chk8(code, 8'hE8);
    $display("flow through test done");
endtask
task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_double;
    t_single;
    t_flow;
    end_of_test;
end
// watchdog: five writes take about 5.2 us
initial begin
    #100000;
    num_errors++;
    end_of_test;
end
endmodule // dlc_host_tb_top

// ---- dlc_map.vh ----
// dlc_map.vh: timing counts and defaults for the converter write controller
// assumes a 50 MHz clock, period 20 ns
`ifndef DLC_MAP_VH
`define DLC_MAP_VH
`define DLC_CLK_PERIOD_NS   20
// least strobe low width, ns
`define DLC_STROBE_MIN_NS   900
// least data hold after the rising edge, ns
`define DLC_HOLD_MIN_NS     50
// least setup of data before strobe falls, ns
`define DLC_SETUP_MIN_NS    20
// cycle counts, least times rounded up
`define DLC_STROBE_CYC ((`DLC_STROBE_MIN_NS+`DLC_CLK_PERIOD_NS-1)/`DLC_CLK_PERIOD_NS)
`define DLC_HOLD_CYC   ((`DLC_HOLD_MIN_NS+`DLC_CLK_PERIOD_NS-1)/`DLC_CLK_PERIOD_NS)
`define DLC_SETUP_CYC  ((`DLC_SETUP_MIN_NS+`DLC_CLK_PERIOD_NS-1)/`DLC_CLK_PERIOD_NS)
// operating modes
`define DLC_MODE_DOUBLE 2'h0
`define DLC_MODE_SINGLE 2'h1
`define DLC_MODE_FLOW   2'h2
`endif
